// file: logic/cmsd_map.svh
`ifndef CMSD_MAP_SVH
`define CMSD_MAP_SVH
`define CM_BANK_TOP 8'h1f
`define CM_BIT_BASE 8'h20
`define CM_BIT_TOP 8'h2f
`define CM_UPPER 8'h80
`define CM_BIT_SFR 8'h80
`define CM_SFR_ROW 8'hf8
`define CM_SP 8'h81
`define CM_DATA_POINTER0_LOW 8'h82
`define CM_DATA_POINTER0_HIGH 8'h83
`define CM_DATA_POINTER1_LOW 8'h84
`define CM_DATA_POINTER1_HIGH 8'h85
`define CM_DPS 8'h86
`define CM_POINTER0_TOP_BYTE 8'h93
`define CM_POINTER1_TOP_BYTE 8'h95
`define CM_INDEXED_MIDDLE_BYTE 8'ha0
`define CM_IE 8'ha8
`define CM_PSW 8'hd0
`define CM_ACC 8'he0
`define CM_INDEXED_TOP_BYTE 8'hea
`define CM_B 8'hf0
`define CM_P0_DR 8'h80
`define CM_P0_PS 8'h89
`define CM_P0_SEL 8'h8a
`define CM_P1_DR 8'h90
`define CM_P1_PS 8'h91
`define CM_P1_SEL 8'ha2
`define CM_P2_DR 8'h98
`define CM_P3_DR 8'hb0
`define CM_P4_DR 8'hc0
`define CM_P5_DR 8'hc8
`define CM_P6_DR 8'hd8
`define CM_P12_DR 8'he8
`define CM_P12_SEL 8'hf2
`define CM_P15_DR 8'hf8
`define CM_PS_OFS 8'h01
`define CM_SEL_OFS 8'h02
`define CM_PSW_RS_LO 3
`define CM_SP_RESET 8'h07
`define CM_SRAM_LO 24'h000000
`define CM_SRAM_HI 24'h001fff
`define CM_SRAM_BLK_BIT 12
`define CM_INTC_LO 24'h004400
`define CM_INTC_HI 24'h0044ff
`define CM_EE_LO 24'h008000
`define CM_EE_HI 24'h008fff
`define CM_ECC_LO 24'h080000
`define CM_ECC_HI 24'h081fff
`define CM_EXTERNAL_MEMORY_INTERFACE_LO 24'h800000
`define CM_EXTERNAL_MEMORY_INTERFACE_HI 24'hffffff
`endif

// file: logic/cmsd_pkg.sv
package cmsd_pkg;
	typedef struct packed {
		logic ramSel;
		logic sfrSel;
		logic [7:0] ramAddr;
		logic [2:0] bitIdx;
	} cmsd_iaccess_t;
	typedef struct packed {
		logic sram;
		logic intc;
		logic eeprom;
		logic ecc;
		logic external_memory_interface;
	} cmsd_xregion_t;
	typedef struct packed {
		logic [6:0] row;
		logic [3:0] col;
	} cmsd_eeaddr_t;
	typedef enum logic [1:0] {
		CMSD_IDLE = 2'b00,
		CMSD_XFER = 2'b01
	} cmsd_xstate_t;
endpackage

// file: logic/cmsd_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "cmsd_map.svh"
// Behaviour
// RULE1: Data bytes 0x00-0x1F form four banks of eight working registers.
// RULE2: Sixteen bytes above the banks are reachable bit by bit.
// RULE3: Lower half reaches the same RAM by direct or indirect access.
// RULE4: Direct accesses to the upper half go to special registers.
// RULE5: Indirect upper accesses and stack go to upper RAM, 256-byte stack.
// RULE6: Select register picks which of two data pointers is used.
// RULE7: Pointer external moves take top byte from the pointer's extension.
// RULE8: Register-indexed moves take top and middle bytes from extension registers.
// RULE9: Extension registers affect only external moves.
// RULE10: Ports 0-6, 12, 15 each get data, select and pin-state registers.
// RULE11: Select bit set drives pin from special data, clear from bus data.
// RULE12: Pin-state register is read-only and shows pin levels.
// RULE13: Extended addresses 0x000000-0x001FFF decode to SRAM.
// RULE14: Extended addresses 0x800000-0xFFFFFF go to external memory interface.
// RULE15: Extended addresses 0x080000-0x081FFF decode to error-correction storage.
// RULE16: Byte storage 0x008000-0x008FFF read directly; writes via programming port.
// RULE17: Byte storage is 128 rows of 16 bytes, row-wise erase and write.
// RULE18: Code fetch continues while byte storage is being written.
// RULE19: No fetch from byte storage and no hardware correction there.
// RULE20: External interface serves one memory type, 8 or 16 bits wide.
// RULE21: The 64 KB code space maps only to main program flash.
// RULE22: Extended addresses 0x004400-0x0044FF decode to interrupt controller.
// RULE23: Unmapped extended reads return zero, writes are ignored.
// RULE24: Core and transfer controller share SRAM when in different 4 KB blocks.
module cmsd_decode import cmsd_pkg::*; #(
	parameter int NPORT = 9
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] iAddr,
	input wire logic iIndirect,
	input wire logic iRegMode,
	input wire logic iBitMode,
	input wire logic iRd,
	input wire logic iWr,
	input wire logic [7:0] iWdata,
	input wire logic stackPush,
	input wire logic stackPop,
	output cmsd_iaccess_t iAccess,
	output logic [7:0] sfrRdata,
	input wire logic dptrInc,
	input wire logic dptrLoad,
	input wire logic [15:0] dptrLoadVal,
	output logic [15:0] dptrActive,
	input wire logic xReq,
	input wire logic xWr,
	input wire logic xViaReg,
	input wire logic [7:0] xRegVal,
	input wire logic [7:0] xWdata,
	output logic xStrobe,
	output logic xWrite,
	output logic [23:0] xAddr,
	output logic [7:0] xWdataOut,
	output cmsd_xregion_t xRegion,
	output cmsd_eeaddr_t eeAddr,
	input wire logic [7:0] sramRdata,
	input wire logic [7:0] intcRdata,
	input wire logic [7:0] eeRdata,
	input wire logic [7:0] eccRdata,
	input wire logic [7:0] emifRdata,
	output logic [7:0] xRdata,
	input wire logic dmaSramReq,
	input wire logic dmaSramBlock,
	output logic sramConflict,
	input wire logic emifWide,
	output logic emifHalfSel,
	input wire logic [15:0] codeAddr,
	output logic [15:0] flashFetchAddr,
	output logic fetchStall,
	input wire logic [NPORT*8-1:0] busPortOut,
	input wire logic [NPORT*8-1:0] pinIn,
	output logic [NPORT*8-1:0] padOut,
	output logic [7:0] pswOut,
	output logic [7:0] accOut,
	output logic [7:0] ieOut
);
	// ****************************************
	// Port register address table
	// ****************************************
	function automatic logic [7:0] portDr(input int i);
		case (i)
			0: portDr = `CM_P0_DR;
			1: portDr = `CM_P1_DR;
			2: portDr = `CM_P2_DR;
			3: portDr = `CM_P3_DR;
			4: portDr = `CM_P4_DR;
			5: portDr = `CM_P5_DR;
			6: portDr = `CM_P6_DR;
			7: portDr = `CM_P12_DR;
			default: portDr = `CM_P15_DR;
		endcase
	endfunction
	function automatic logic [7:0] portPs(input int i);
		if (i == 0) begin
			portPs = `CM_P0_PS;
		end else begin
			portPs = portDr(i) + `CM_PS_OFS;
		end
	endfunction
	function automatic logic [7:0] portSel(input int i);
		case (i)
			0: portSel = `CM_P0_SEL;
			1: portSel = `CM_P1_SEL;
			7: portSel = `CM_P12_SEL;
			default: portSel = portDr(i) + `CM_SEL_OFS;
		endcase
	endfunction
	function automatic logic inRange(input logic [23:0] a, input logic [23:0] lo,
		input logic [23:0] hi);
		inRange = (a >= lo) && (a <= hi);
	endfunction

	// ****************************************
	// Core registers
	// ****************************************
	logic [7:0] sp_reg, psw_reg, acc_reg, b_reg, ie_reg, dps_reg;
	logic [15:0] data_pointer_zero_reg, data_pointer_one_reg;
	logic [7:0] pointer0_top_byte_reg, pointer1_top_byte_reg, indexed_top_byte_reg, indexed_middle_byte_reg;
	logic [7:0] sfrRdata_reg;

	// ****************************************
	// Internal data space decode
	// ****************************************
	wire logic [7:0] bankAddr = {3'h0, psw_reg[`CM_PSW_RS_LO +: 2], iAddr[2:0]}; // RULE1
	wire logic [7:0] bitLow = `CM_BIT_BASE + {4'h0, iAddr[6:3]}; // RULE2
	wire logic [7:0] bitHigh = iAddr & `CM_SFR_ROW;
	wire logic [7:0] bitByte = (iAddr < `CM_BIT_SFR) ? bitLow : bitHigh;
	wire logic [7:0] spInc = sp_reg + 8'h01;
	wire logic stackOp = stackPush | stackPop;
	wire logic [7:0] effAddr = stackPush ? spInc :
		stackPop ? sp_reg :
		iRegMode ? bankAddr :
		iBitMode ? bitByte : iAddr;
	wire logic effIndirect = stackOp | iIndirect; // RULE5
	wire logic upperHalf = effAddr >= `CM_UPPER;
	wire logic toSfr = upperHalf & ~effIndirect; // RULE4
	assign iAccess.sfrSel = toSfr;
	assign iAccess.ramSel = ~toSfr; // RULE3 RULE5
	assign iAccess.ramAddr = effAddr;
	assign iAccess.bitIdx = iBitMode ? iAddr[2:0] : 3'h0;
	wire logic sfrWr = iWr & toSfr & ~stackOp;
	wire logic sfrRd = iRd & toSfr & ~stackOp;
	function automatic logic hit(input logic [7:0] a);
		hit = sfrWr && (effAddr == a);
	endfunction

	// ****************************************
	// I/O port special registers
	// ****************************************
	logic [7:0] portOut_reg [NPORT];
	logic [7:0] portSel_reg [NPORT];
	logic [7:0] pinS1_reg [NPORT];
	logic [7:0] pinS2_reg [NPORT];
	logic [7:0] pinS3_reg [NPORT];
	logic [7:0] pinState_reg [NPORT];
	logic [7:0] portRd [NPORT+1];
	assign portRd[0] = 8'h00;
	genvar g;
	generate
		for (g = 0; g < NPORT; g++) begin : gPort // RULE10
			wire logic [7:0] busBits = busPortOut[g*8 +: 8];
			wire logic [7:0] agree = ~(pinS2_reg[g] ^ pinS3_reg[g]);
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					portOut_reg[g] <= 8'h00;
					portSel_reg[g] <= 8'h00;
					pinS1_reg[g] <= 8'h00;
					pinS2_reg[g] <= 8'h00;
					pinS3_reg[g] <= 8'h00;
					pinState_reg[g] <= 8'h00;
				end else begin
					if (hit(portDr(g))) portOut_reg[g] <= iWdata;
					if (hit(portSel(g))) portSel_reg[g] <= iWdata;
					pinS1_reg[g] <= pinIn[g*8 +: 8];
					pinS2_reg[g] <= pinS1_reg[g];
					pinS3_reg[g] <= pinS2_reg[g];
					// A pin change is taken only once the two late stages agree.
					pinState_reg[g] <= (agree & pinS2_reg[g]) | (~agree & pinState_reg[g]);
				end
			end
			assign padOut[g*8 +: 8] = (portSel_reg[g] & portOut_reg[g]) |
				(~portSel_reg[g] & busBits); // RULE11
			// Pin-state has no write path, so software writes to it are dropped.
			assign portRd[g+1] = portRd[g] |
				((effAddr == portDr(g)) ? portOut_reg[g] : 8'h00) |
				((effAddr == portSel(g)) ? portSel_reg[g] : 8'h00) |
				((effAddr == portPs(g)) ? pinState_reg[g] : 8'h00); // RULE12
		end
	endgenerate

	// ****************************************
	// Special register read mux
	// ****************************************
	wire logic [7:0] coreRd =
		(effAddr == `CM_SP) ? sp_reg :
		(effAddr == `CM_DATA_POINTER0_LOW) ? data_pointer_zero_reg[7:0] :
		(effAddr == `CM_DATA_POINTER0_HIGH) ? data_pointer_zero_reg[15:8] :
		(effAddr == `CM_DATA_POINTER1_LOW) ? data_pointer_one_reg[7:0] :
		(effAddr == `CM_DATA_POINTER1_HIGH) ? data_pointer_one_reg[15:8] :
		(effAddr == `CM_DPS) ? dps_reg :
		(effAddr == `CM_POINTER0_TOP_BYTE) ? pointer0_top_byte_reg :
		(effAddr == `CM_POINTER1_TOP_BYTE) ? pointer1_top_byte_reg :
		(effAddr == `CM_INDEXED_MIDDLE_BYTE) ? indexed_middle_byte_reg :
		(effAddr == `CM_INDEXED_TOP_BYTE) ? indexed_top_byte_reg :
		(effAddr == `CM_IE) ? ie_reg :
		(effAddr == `CM_PSW) ? psw_reg :
		(effAddr == `CM_ACC) ? acc_reg :
		(effAddr == `CM_B) ? b_reg : 8'h00;
	wire logic [7:0] sfrRdNext = coreRd | portRd[NPORT];

	// ****************************************
	// Data pointers
	// ****************************************
	wire logic useDptr1 = dps_reg[0]; // RULE6
	assign dptrActive = useDptr1 ? data_pointer_one_reg : data_pointer_zero_reg;
	wire logic [15:0] dptrNext = dptrLoad ? dptrLoadVal : dptrActive + 16'h0001;
	wire logic dptrUpd = dptrLoad | dptrInc;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sp_reg <= `CM_SP_RESET;
			psw_reg <= 8'h00;
			acc_reg <= 8'h00;
			b_reg <= 8'h00;
			ie_reg <= 8'h00;
			dps_reg <= 8'h00;
			pointer0_top_byte_reg <= 8'h00;
			pointer1_top_byte_reg <= 8'h00;
			indexed_top_byte_reg <= 8'h00;
			indexed_middle_byte_reg <= 8'h00;
			sfrRdata_reg <= 8'h00;
		end else begin
			if (stackPush) begin
				sp_reg <= spInc;
			end else if (stackPop) begin
				sp_reg <= sp_reg - 8'h01;
			end else if (hit(`CM_SP)) begin
				sp_reg <= iWdata;
			end
			if (hit(`CM_PSW)) psw_reg <= iWdata;
			if (hit(`CM_ACC)) acc_reg <= iWdata;
			if (hit(`CM_B)) b_reg <= iWdata;
			if (hit(`CM_IE)) ie_reg <= iWdata;
			if (hit(`CM_DPS)) dps_reg <= iWdata;
			if (hit(`CM_POINTER0_TOP_BYTE)) pointer0_top_byte_reg <= iWdata;
			if (hit(`CM_POINTER1_TOP_BYTE)) pointer1_top_byte_reg <= iWdata;
			if (hit(`CM_INDEXED_TOP_BYTE)) indexed_top_byte_reg <= iWdata;
			if (hit(`CM_INDEXED_MIDDLE_BYTE)) indexed_middle_byte_reg <= iWdata;
			if (sfrRd) sfrRdata_reg <= sfrRdNext;
		end
	end

	// A pointer operation from the core wins over a same-cycle register write.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			data_pointer_zero_reg <= 16'h0000;
			data_pointer_one_reg <= 16'h0000;
		end else begin
			if (dptrUpd && !useDptr1) begin
				data_pointer_zero_reg <= dptrNext;
			end else begin
				if (hit(`CM_DATA_POINTER0_LOW)) data_pointer_zero_reg[7:0] <= iWdata;
				if (hit(`CM_DATA_POINTER0_HIGH)) data_pointer_zero_reg[15:8] <= iWdata;
			end
			if (dptrUpd && useDptr1) begin
				data_pointer_one_reg <= dptrNext;
			end else begin
				if (hit(`CM_DATA_POINTER1_LOW)) data_pointer_one_reg[7:0] <= iWdata;
				if (hit(`CM_DATA_POINTER1_HIGH)) data_pointer_one_reg[15:8] <= iWdata;
			end
		end
	end
	assign sfrRdata = sfrRdata_reg;
	assign pswOut = psw_reg;
	assign accOut = acc_reg;
	assign ieOut = ie_reg;

	// ****************************************
	// Extended data space
	// ****************************************
	// Extension bytes join only the external-move address path below.
	wire logic [7:0] dpxSel = useDptr1 ? pointer1_top_byte_reg : pointer0_top_byte_reg;
	wire logic [23:0] ptrAddr = {dpxSel, dptrActive}; // RULE7 RULE9
	wire logic [23:0] regAddr = {indexed_top_byte_reg, indexed_middle_byte_reg, xRegVal}; // RULE8 RULE9
	wire logic [23:0] newAddr = xViaReg ? regAddr : ptrAddr;
	cmsd_xregion_t rgn;
	assign rgn.sram = inRange(newAddr, `CM_SRAM_LO, `CM_SRAM_HI); // RULE13
	assign rgn.intc = inRange(newAddr, `CM_INTC_LO, `CM_INTC_HI); // RULE22
	assign rgn.eeprom = inRange(newAddr, `CM_EE_LO, `CM_EE_HI); // RULE16
	assign rgn.ecc = inRange(newAddr, `CM_ECC_LO, `CM_ECC_HI); // RULE15
	assign rgn.external_memory_interface = inRange(newAddr, `CM_EXTERNAL_MEMORY_INTERFACE_LO, `CM_EXTERNAL_MEMORY_INTERFACE_HI); // RULE14
	cmsd_xstate_t xState_reg;
	logic [23:0] xAddr_reg;
	logic [7:0] xWdata_reg;
	cmsd_xregion_t xRegion_reg;
	logic xWrite_reg;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			xState_reg <= CMSD_IDLE;
			xAddr_reg <= 24'h000000;
			xWdata_reg <= 8'h00;
			xRegion_reg <= '0;
			xWrite_reg <= 1'b0;
		end else begin
			case (xState_reg)
				CMSD_IDLE: begin
					if (xReq) begin
						xState_reg <= CMSD_XFER;
						xAddr_reg <= newAddr;
						xWdata_reg <= xWdata;
						xRegion_reg <= rgn;
						// Byte storage is written only through its programming port.
						xWrite_reg <= xWr & ~rgn.eeprom; // RULE16 RULE23
					end
				end
				CMSD_XFER: begin
					xState_reg <= xReq ? CMSD_XFER : CMSD_IDLE;
					xAddr_reg <= newAddr;
					xWdata_reg <= xWdata;
					xRegion_reg <= xReq ? rgn : '0;
					xWrite_reg <= xReq & xWr & ~rgn.eeprom;
				end
				default: begin
					xState_reg <= CMSD_IDLE;
				end
			endcase
		end
	end
	assign xStrobe = (xState_reg == CMSD_XFER);
	assign xAddr = xAddr_reg;
	assign xWdataOut = xWdata_reg;
	assign xRegion = xRegion_reg;
	wire logic xMapped = |xRegion_reg;
	assign xWrite = xWrite_reg & xMapped & xStrobe; // RULE23
	assign eeAddr.row = xAddr_reg[10:4]; // RULE17
	assign eeAddr.col = xAddr_reg[3:0];
	// Unmapped reads fall through every term and return zero.
	assign xRdata = (xRegion_reg.sram ? sramRdata : 8'h00) |
		(xRegion_reg.intc ? intcRdata : 8'h00) |
		(xRegion_reg.eeprom ? eeRdata : 8'h00) |
		(xRegion_reg.ecc ? eccRdata : 8'h00) |
		(xRegion_reg.external_memory_interface ? emifRdata : 8'h00); // RULE23
	assign sramConflict = xStrobe & xRegion_reg.sram & dmaSramReq &
		(xAddr_reg[`CM_SRAM_BLK_BIT] == dmaSramBlock); // RULE24
	// One memory type at a time; a wide part takes a halfword select.
	assign emifHalfSel = emifWide & xAddr_reg[0]; // RULE20

	// ****************************************
	// Code space
	// ****************************************
	// Fetch has no path to byte storage and never waits on its writes.
	assign flashFetchAddr = codeAddr; // RULE21 RULE19
	assign fetchStall = 1'b0; // RULE18
endmodule
`default_nettype wire

// file: dv/cmsd_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Far-side memories
// ****************
// Every region answers at once and never idles at zero, so a zero seen on
// an unmapped move can only come from the decode itself.
module cmsd_mem_model (
	input wire logic [23:0] xAddr,
	output logic [7:0] sramRdata,
	output logic [7:0] intcRdata,
	output logic [7:0] eeRdata,
	output logic [7:0] eccRdata,
	output logic [7:0] emifRdata
);
	assign sramRdata = xAddr[7:0] ^ 8'h11;
	assign intcRdata = xAddr[7:0] ^ 8'h22;
	assign eeRdata = xAddr[7:0] ^ 8'h33;
	assign eccRdata = xAddr[7:0] ^ 8'h44;
	assign emifRdata = xAddr[7:0] ^ 8'h55;
endmodule
`default_nettype wire

// file: dv/cmsd_decode_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Decode checker
// ****************
module cmsd_decode_monitor import cmsd_pkg::*; (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] iAddr,
	input wire logic iIndirect,
	input wire logic iRegMode,
	input wire logic iBitMode,
	input wire logic iRd,
	input wire logic iWr,
	input wire cmsd_iaccess_t iAccess,
	input wire logic [7:0] pswOut,
	input wire logic xReq,
	input wire logic xViaReg,
	input wire logic [15:0] dptrActive,
	input wire logic xStrobe,
	input wire logic xWrite,
	input wire logic [23:0] xAddr,
	input wire cmsd_xregion_t xRegion,
	input wire logic [7:0] xRdata,
	input wire logic dmaSramReq,
	input wire logic dmaSramBlock,
	input wire logic sramConflict,
	input wire logic [15:0] codeAddr,
	input wire logic [15:0] flashFetchAddr,
	input wire logic fetchStall
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	wire logic acc = iRd || iWr;
	wire logic [4:0] expReg = {xAddr <= 24'h001fff, xAddr[23:8] == 16'h0044,
		xAddr[23:12] == 12'h008, xAddr[23:13] == 11'h040, xAddr[23]};
	a_lower_same: assert property (
		acc && !iRegMode && !iBitMode && !iAddr[7] |-> iAccess.ramSel && iAccess.ramAddr == iAddr)
		else $error("lower data byte not steered to ram");
	a_direct_sfr: assert property (
		acc && !iIndirect && !iRegMode && !iBitMode && iAddr[7] |-> iAccess.sfrSel && !iAccess.ramSel)
		else $error("direct upper access not steered to special registers");
	a_indirect_ram: assert property (
		acc && iIndirect && !iRegMode && iAddr[7]
		|-> iAccess.ramSel && !iAccess.sfrSel && iAccess.ramAddr == iAddr)
		else $error("indirect upper access not steered to ram");
	a_bit_area: assert property (
		acc && iBitMode && !iAddr[7]
		|-> iAccess.ramAddr == {4'h2, iAddr[6:3]} && iAccess.bitIdx == iAddr[2:0])
		else $error("bit address decoded wrongly");
	a_bank_reg: assert property (
		acc && iRegMode |-> iAccess.ramAddr == {3'b000, pswOut[4:3], iAddr[2:0]})
		else $error("working register bank address wrong");
	a_ptr_addr: assert property (
		xReq && !xViaReg |=> xStrobe && xAddr[15:0] == $past(dptrActive))
		else $error("pointer move address wrong");
	a_region_map: assert property (
		xStrobe |-> xRegion == expReg)
		else $error("extended region decode wrong");
	a_unmapped_zero: assert property (
		xStrobe && expReg == 5'h00 |-> xRdata == 8'h00 && !xWrite)
		else $error("unmapped move not quiet");
	a_ee_nowrite: assert property (
		xStrobe && xRegion.eeprom |-> !xWrite)
		else $error("byte storage written directly");
	a_fetch_flash: assert property (
		flashFetchAddr == codeAddr && !fetchStall)
		else $error("code fetch not from main flash");
	a_sram_share: assert property (
		xStrobe && xRegion.sram |-> sramConflict == (dmaSramReq && dmaSramBlock == xAddr[12]))
		else $error("sram sharing conflict wrong");
endmodule
bind cmsd_decode cmsd_decode_monitor mon (.sys_clk, .rst_n, .iAddr, .iIndirect, .iRegMode,
	.iBitMode, .iRd, .iWr, .iAccess, .pswOut, .xReq, .xViaReg, .dptrActive, .xStrobe, .xWrite,
	.xAddr, .xRegion, .xRdata, .dmaSramReq, .dmaSramBlock, .sramConflict, .codeAddr,
	.flashFetchAddr, .fetchStall);
`default_nettype wire

// file: dv/test_cmsd_decode.sv
`timescale 1ns/1ps
`default_nettype none
module test_cmsd_decode import cmsd_pkg::*;;
	logic sys_clk, rst_n, iIndirect, iRegMode, iBitMode, iRd, iWr, stackPush, stackPop;
	logic dptrInc, dptrLoad, xReq, xWr, xViaReg, dmaSramReq, dmaSramBlock, emifWide;
	logic xStrobe, xWrite, sramConflict, emifHalfSel, fetchStall;
	logic [7:0] iAddr, iWdata, sfrRdata, xRegVal, xWdata, xWdataOut, xRdata, pswOut, accOut;
	logic [7:0] ieOut, sramRdata, intcRdata, eeRdata, eccRdata, emifRdata;
	logic [15:0] dptrLoadVal, dptrActive, codeAddr, flashFetchAddr;
	logic [23:0] xAddr;
	logic [71:0] busPortOut, pinIn, padOut;
	cmsd_iaccess_t iAccess;
	cmsd_xregion_t xRegion;
	cmsd_eeaddr_t eeAddr;
	int miscompares = 0;
	int compares = 0;
	logic [7:0] drA[9] = '{8'h80, 8'h90, 8'h98, 8'hb0, 8'hc0, 8'hc8, 8'hd8, 8'he8, 8'hf8};
	logic [7:0] selA[9] = '{8'h8a, 8'ha2, 8'h9a, 8'hb2, 8'hc2, 8'hca, 8'hda, 8'hf2, 8'hfa};
	// Port 0 pin state sits apart from its data register, since 0x81 is the stack pointer.
	logic [7:0] psA[9] = '{8'h89, 8'h91, 8'h99, 8'hb1, 8'hc1, 8'hc9, 8'hd9, 8'he9, 8'hf9};
	logic [23:0] tA[12] = '{24'h000010, 24'h001fff, 24'h004400, 24'h002000, 24'h0044ff,
		24'h008fff, 24'h008000, 24'h081fff, 24'h080000, 24'h7fffff, 24'h800000, 24'hffffff};
	cmsd_decode dut (.sys_clk, .rst_n, .iAddr, .iIndirect, .iRegMode, .iBitMode, .iRd, .iWr,
		.iWdata, .stackPush, .stackPop, .iAccess, .sfrRdata, .dptrInc, .dptrLoad, .dptrLoadVal,
		.dptrActive, .xReq, .xWr, .xViaReg, .xRegVal, .xWdata, .xStrobe, .xWrite, .xAddr,
		.xWdataOut, .xRegion, .eeAddr, .sramRdata, .intcRdata, .eeRdata, .eccRdata, .emifRdata,
		.xRdata, .dmaSramReq, .dmaSramBlock, .sramConflict, .emifWide, .emifHalfSel, .codeAddr,
		.flashFetchAddr, .fetchStall, .busPortOut, .pinIn, .padOut, .pswOut, .accOut, .ieOut);
	cmsd_mem_model mem (.xAddr, .sramRdata, .intcRdata, .eeRdata, .eccRdata, .emifRdata);
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %0t byte got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chkA(input logic [23:0] g, input logic [23:0] e);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %0t address got %h exp %h", $time, g, e);
		end
	endtask
	task automatic final_report();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		iAddr = a;
		iWdata = d;
		iWr = 1'b1;
		@(negedge sys_clk);
		iWr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge sys_clk);
		iAddr = a;
		iRd = 1'b1;
		@(negedge sys_clk);
		iRd = 1'b0;
		chk8(sfrRdata, e);
	endtask
	task automatic acc(input logic [7:0] a, input logic [2:0] m, input logic [1:0] es,
		input logic [7:0] ea);
		@(negedge sys_clk);
		iAddr = a;
		{iIndirect, iRegMode, iBitMode} = m;
		iRd = 1'b1;
		#1;
		chk8({6'h00, iAccess.sfrSel, iAccess.ramSel}, {6'h00, es});
		if (es[0]) chk8(iAccess.ramAddr, ea);
		@(negedge sys_clk);
		iRd = 1'b0;
		{iIndirect, iRegMode, iBitMode} = 3'b000;
	endtask
	task automatic ld(input logic [15:0] v);
		@(negedge sys_clk);
		dptrLoadVal = v;
		dptrLoad = 1'b1;
		@(negedge sys_clk);
		dptrLoad = 1'b0;
		chkA({8'h00, dptrActive}, {8'h00, v});
	endtask
	task automatic xm(input logic [23:0] a, input logic w);
		logic [4:0] r;
		logic [7:0] e;
		r = {a <= 24'h001fff, a[23:8] == 16'h0044, a[23:12] == 12'h008, a[23:13] == 11'h040, a[23]};
		e = r[4] ? a[7:0] ^ 8'h11 : r[3] ? a[7:0] ^ 8'h22 : r[2] ? a[7:0] ^ 8'h33 :
			r[1] ? a[7:0] ^ 8'h44 : r[0] ? a[7:0] ^ 8'h55 : 8'h00;
		@(negedge sys_clk);
		xWr = w;
		xReq = 1'b1;
		@(negedge sys_clk);
		xReq = 1'b0;
		chkA(xAddr, a);
		chk8({xStrobe, xWrite, emifHalfSel, xRegion}, {1'b1, w && r != 5'h00 && !r[2], a[0], r});
		chk8(xRdata, e);
		chk8(xWdataOut, 8'h3c);
		if (r[2]) chkA({13'h0000, eeAddr}, {13'h0000, a[10:0]});
	endtask
	initial begin
		#200000;
		miscompares++;
		final_report();
	end
	initial begin
		{iIndirect, iRegMode, iBitMode, iRd, iWr, stackPush, stackPop, dptrInc, dptrLoad} = '0;
		{xReq, xWr, xViaReg} = '0;
		{dmaSramReq, dmaSramBlock, emifWide} = 3'b111;
		{iAddr, iWdata, xRegVal} = '0;
		xWdata = 8'h3c;
		dptrLoadVal = 16'h0000;
		codeAddr = 16'hbeef;
		busPortOut = {9{8'hc3}};
		pinIn = '0;
		rst_n = 1'b0;
		repeat (3) @(negedge sys_clk);
		rst_n = 1'b1;
		rd(8'h81, 8'h07);
		@(negedge sys_clk);
		stackPush = 1'b1;
		#1;
		chk8({iAccess.ramSel, iAccess.ramAddr[6:0]}, 8'h88);
		@(negedge sys_clk);
		stackPush = 1'b0;
		rd(8'h81, 8'h08);
		for (int i = 0; i < 9; i++) begin
			pinIn[i*8+:8] = 8'h96 ^ 8'(i);
			wr(drA[i], 8'h5a ^ 8'(i));
			wr(selA[i], 8'h0f);
			chk8(padOut[i*8+:8], ((8'h5a ^ 8'(i)) & 8'h0f) | 8'hc0);
			rd(drA[i], 8'h5a ^ 8'(i));
			rd(selA[i], 8'h0f);
			wr(psA[i], 8'hff);
			rd(psA[i], 8'h96 ^ 8'(i));
		end
		acc(8'h45, 3'b000, 2'b01, 8'h45);
		acc(8'h45, 3'b100, 2'b01, 8'h45);
		acc(8'h90, 3'b100, 2'b01, 8'h90);
		acc(8'h90, 3'b000, 2'b10, 8'h00);
		acc(8'h7f, 3'b001, 2'b01, 8'h2f);
		wr(8'hd0, 8'h18);
		acc(8'h05, 3'b010, 2'b01, 8'h1d);
		wr(8'he0, 8'ha1);
		chk8(accOut, 8'ha1);
		wr(8'ha8, 8'h85);
		chk8(ieOut, 8'h85);
		for (int i = 0; i < 12; i++) begin
			wr(8'h93, tA[i][23:16]);
			ld(tA[i][15:0]);
			xm(tA[i], i[0]);
		end
		wr(8'h86, 8'h01);
		wr(8'h95, 8'h08);
		ld(16'h1234);
		xm(24'h081234, 1'b0);
		wr(8'h86, 8'h00);
		chkA({8'h00, dptrActive}, 24'h00ffff);
		@(negedge sys_clk);
		dptrInc = 1'b1;
		@(negedge sys_clk);
		dptrInc = 1'b0;
		chkA({8'h00, dptrActive}, 24'h000000);
		wr(8'hea, 8'h00);
		wr(8'ha0, 8'h44);
		xViaReg = 1'b1;
		xRegVal = 8'h20;
		xm(24'h004420, 1'b1);
		xViaReg = 1'b0;
		final_report();
	end
endmodule
`default_nettype wire
